// ### shared/cpsl_regs.svh
// register map, reset values and timing figures of the control-pin block
`ifndef CPSL_REGS_SVH
`define CPSL_REGS_SVH
`define CPSL_NCH          4
`define CPSL_AW           8
`define CPSL_OFS_CTRL     8'h00
`define CPSL_OFS_DELAY    8'h04
`define CPSL_OFS_FMASK    8'h08
`define CPSL_OFS_PERIOD   8'h0C
`define CPSL_OFS_STATUS   8'h10
`define CPSL_RST_BEH      4'h0
`define CPSL_RST_MASK     4'h0
`define CPSL_RST_DELAY    20'h00000
`define CPSL_DLY_W        5
`define CPSL_DLY_STRIDE   8
`define CPSL_SLOT_SHIFT   5
`define CPSL_CLK_HZ       50000000
`define CPSL_PWM_HZ       1000
`define CPSL_CNT_W        16
`define CPSL_ST_ALIGN     0
`define CPSL_ST_EN        1
`define CPSL_ST_FAULT     2
`define CPSL_ST_RUN       4
`define CPSL_ST_RAW       8
`define CPSL_ST_MODE      12
`endif

// ### shared/cpsl_pkg.sv
// types shared by the control-pin block
package cpsl_pkg;
  typedef enum logic [1:0] {M_RESET, M_RUN, M_HOLD} cpsl_mode_e;
  typedef struct packed {
    logic [3:0]  beh;
    logic [3:0]  mask;
    logic [19:0] delay;
    logic [15:0] period;
  } cpsl_cfg_s;
  typedef struct packed {
    logic [3:0] run;
    logic [3:0] freeze;
    logic [3:0] start;
  } cpsl_chan_s;
endpackage

// ### core/cpsl_sync2.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module cpsl_sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### core/cpsl_ctrl.sv
// control-pin logic: resets, enable, phase alignment, fault pin, apb registers
//
// Notes on behaviour
// - low analog or digital supply turns all channels off and restores defaults.
// - while chip reset pin is low, channels stay off, registers at defaults.
// - enable low turns each channel off or freezes it, per its setting.
// - after reset every channel is set to switch off on enable low.
// - all internal timing derives from the main clock.
// - serial messages are handled only while the main clock runs.
// - serial-domain signals are resynchronised into the main clock domain.
// - channel period start lags alignment edge by delay times period/32.
// - an alignment rising edge restarts the channel periods.
// - every alignment event sets a sticky status bit.
// - reading the status register clears the sticky alignment bit.
// - fault pin pulls low while any unmasked fault is present and no reset source is active.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "cpsl_regs.svh"
module cpsl_ctrl #(
  parameter int PERIOD_CLKS = `CPSL_CLK_HZ / `CPSL_PWM_HZ
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`CPSL_AW-1:0]       paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      chip_reset_n,
  input  wire logic                      analog_supply_ok,
  input  wire logic                      digital_supply_ok,
  input  wire logic                      enable_pin,
  input  wire logic                      align_pin,
  input  wire logic                      serial_msg_toggle,
  input  wire logic [`CPSL_NCH-1:0]      fault_detect,
  output cpsl_pkg::cpsl_chan_s           chan,
  output logic                           serial_msg,
  output logic                           fault_out,
  output logic                           fault_oe_n
);
  import cpsl_pkg::*;

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  logic [5:0] pin_sync;
  logic       rst_pin_s;
  logic       sup_a_s;
  logic       sup_d_s;
  logic       en_s;
  logic       align_s;
  logic       tgl_s;

  // every pin is asynchronous to pclk, including the serial-domain toggle
  cpsl_sync2 #(.W(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({serial_msg_toggle, align_pin, enable_pin, digital_supply_ok, analog_supply_ok, chip_reset_n}),
    .q       (pin_sync)
  );
  assign {tgl_s, align_s, en_s, sup_d_s, sup_a_s, rst_pin_s} = pin_sync;

  // ****************************************************************
  // edge detection and chip mode
  // ****************************************************************
  cpsl_mode_e mode;
  cpsl_mode_e next_mode;
  logic       align_d;
  logic       tgl_d;
  logic       soft_rst;
  logic       align_rise;
  logic       tgl_edge;

  // any reset source forces defaults; synced, so glitch-free inside the core
  assign soft_rst   = !rst_pin_s || !sup_a_s || !sup_d_s;
  assign align_rise = align_s && !align_d;
  assign tgl_edge   = tgl_s ^ tgl_d;

  // mode follows the reset sources first, then the enable level
  always_comb begin
    if (soft_rst) begin
      next_mode = M_RESET;
    end else if (!en_s) begin
      next_mode = M_HOLD;
    end else begin
      next_mode = M_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode    <= M_RESET;
      align_d <= 1'b0;
      tgl_d   <= 1'b0;
    end else begin
      mode    <= next_mode;
      align_d <= align_s;
      tgl_d   <= tgl_s;
    end
  end

  // ****************************************************************
  // apb register file
  // ****************************************************************
  cpsl_cfg_s  cfg;
  cpsl_cfg_s  next_cfg;
  logic       align_seen;
  logic       next_align_seen;
  logic [31:0] next_prdata;
  logic       next_pready;
  logic       next_pslverr;
  logic       acc_done;
  logic       hit;
  logic       stat_read;

  // a register that is hit decodes to one of the five word offsets
  function automatic logic addr_hit(input logic [`CPSL_AW-1:0] a);
    addr_hit = (a == `CPSL_OFS_CTRL) || (a == `CPSL_OFS_DELAY) || (a == `CPSL_OFS_FMASK)
            || (a == `CPSL_OFS_PERIOD) || (a == `CPSL_OFS_STATUS);
  endfunction

  assign acc_done  = psel && penable && pready;
  assign hit       = addr_hit(paddr);
  assign stat_read = acc_done && !pwrite && (paddr == `CPSL_OFS_STATUS);

  // no wait state: answer is prepared in the setup cycle, given in the access cycle
  always_comb begin
    next_pready  = psel && !penable && !pready;
    next_pslverr = psel && !penable && !hit;
    next_prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CPSL_OFS_CTRL:   next_prdata[3:0]  = cfg.beh;
        `CPSL_OFS_DELAY:  begin
          for (int i = 0; i < `CPSL_NCH; i++) begin
            next_prdata[i*`CPSL_DLY_STRIDE +: `CPSL_DLY_W] = cfg.delay[i*`CPSL_DLY_W +: `CPSL_DLY_W];
          end
        end
        `CPSL_OFS_FMASK:  next_prdata[3:0]  = cfg.mask;
        `CPSL_OFS_PERIOD: next_prdata[15:0] = cfg.period;
        `CPSL_OFS_STATUS: begin
          next_prdata[`CPSL_ST_ALIGN]    = align_seen;
          next_prdata[`CPSL_ST_EN]       = en_s;
          next_prdata[`CPSL_ST_FAULT]    = !fault_oe_n;
          next_prdata[`CPSL_ST_RUN +: 4] = chan.run;
          next_prdata[`CPSL_ST_RAW +: 4] = fault_detect;
          next_prdata[`CPSL_ST_MODE +: 2] = mode;
        end
        default:          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // configuration writes; the internal reset restores every default
  always_comb begin
    next_cfg = cfg;
    if (soft_rst) begin
      next_cfg.beh    = `CPSL_RST_BEH;
      next_cfg.mask   = `CPSL_RST_MASK;
      next_cfg.delay  = `CPSL_RST_DELAY;
      next_cfg.period = 16'(PERIOD_CLKS);
    end else if (acc_done && pwrite) begin
      unique case (paddr)
        `CPSL_OFS_CTRL:   next_cfg.beh    = pwdata[3:0];
        `CPSL_OFS_DELAY:  begin
          for (int i = 0; i < `CPSL_NCH; i++) begin
            next_cfg.delay[i*`CPSL_DLY_W +: `CPSL_DLY_W] = pwdata[i*`CPSL_DLY_STRIDE +: `CPSL_DLY_W];
          end
        end
        `CPSL_OFS_FMASK:  next_cfg.mask   = pwdata[3:0];
        `CPSL_OFS_PERIOD: next_cfg.period = pwdata[15:0];
        default:          next_cfg = cfg;
      endcase
    end
  end

  // sticky alignment flag: a new event in the read cycle wins over the clear
  always_comb begin
    if (soft_rst) begin
      next_align_seen = 1'b0;
    end else if (align_rise) begin
      next_align_seen = 1'b1;
    end else if (stat_read) begin
      next_align_seen = 1'b0;
    end else begin
      next_align_seen = align_seen;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.beh    <= `CPSL_RST_BEH;
      cfg.mask   <= `CPSL_RST_MASK;
      cfg.delay  <= `CPSL_RST_DELAY;
      cfg.period <= 16'(PERIOD_CLKS);
      align_seen <= 1'b0;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      cfg        <= next_cfg;
      align_seen <= next_align_seen;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  // ****************************************************************
  // period counter and channel control
  // ****************************************************************
  logic [`CPSL_CNT_W-1:0] cnt;
  logic [`CPSL_CNT_W-1:0] next_cnt;
  cpsl_chan_s             next_chan;
  logic                   next_serial_msg;
  logic                   next_fault_oe_n;

  // start point of a channel: delay slots of period/32 each
  function automatic logic [`CPSL_CNT_W-1:0] slot_pos(input logic [`CPSL_DLY_W-1:0] d,
                                                     input logic [`CPSL_CNT_W-1:0] per);
    logic [`CPSL_CNT_W+`CPSL_DLY_W-1:0] p;
    p = (per >> `CPSL_SLOT_SHIFT) * d;
    slot_pos = p[`CPSL_CNT_W-1:0];
  endfunction

  // all timing counts pclk; an alignment edge restarts the period
  always_comb begin
    if (soft_rst || align_rise) begin
      next_cnt = '0;
    end else if (cnt >= cfg.period - 16'h0001) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end

  // channel state: off in reset; enable low picks off or freeze per channel
  always_comb begin
    next_chan = chan;
    for (int i = 0; i < `CPSL_NCH; i++) begin
      unique case (mode)
        M_RESET: begin
          next_chan.run[i]    = 1'b0;
          next_chan.freeze[i] = 1'b0;
          next_chan.start[i]  = 1'b0;
        end
        M_HOLD: begin
          next_chan.run[i]    = chan.run[i] && cfg.beh[i];
          next_chan.freeze[i] = cfg.beh[i];
          next_chan.start[i]  = 1'b0;
        end
        M_RUN: begin
          next_chan.run[i]    = 1'b1;
          next_chan.freeze[i] = 1'b0;
          next_chan.start[i]  = !align_rise && (cnt == slot_pos(cfg.delay[i*`CPSL_DLY_W +: `CPSL_DLY_W],
                                                                cfg.period));
        end
      endcase
    end
  end

  // serial events are seen only through pclk, so a stopped clock drops them
  assign next_serial_msg = tgl_edge && !soft_rst;
  // open drain: enable low means the pin is pulled low
  assign next_fault_oe_n = soft_rst || !(|(fault_detect & ~cfg.mask));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt        <= '0;
      chan       <= '0;
      serial_msg <= 1'b0;
      fault_out  <= 1'b0;
      fault_oe_n <= 1'b1;
    end else begin
      cnt        <= next_cnt;
      chan       <= next_chan;
      serial_msg <= next_serial_msg;
      fault_out  <= 1'b0;
      fault_oe_n <= next_fault_oe_n;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_align_event;
    align_rise && !soft_rst;
  endsequence

  sequence s_restart;
    cnt == '0;
  endsequence

  // flag stands at least one more cycle unless a status read or reset took it away
  sequence s_flag_kept;
    align_seen ##1 (align_seen || $past(stat_read) || $past(soft_rst));
  endsequence

  a_supply_reset_off: assert property (@(posedge pclk) disable iff (!presetn)
    (!sup_a_s || !sup_d_s) |-> ##2 (chan.run == 4'h0 && chan.start == 4'h0))
    else $error("channels still on after supply undervoltage");

  a_pin_reset_defaults: assert property (@(posedge pclk) disable iff (!presetn)
    !rst_pin_s |=> (cfg.beh == `CPSL_RST_BEH && cfg.mask == `CPSL_RST_MASK && !align_seen))
    else $error("registers not at defaults during chip reset");

  a_hold_off_chan: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == M_HOLD) |=> ((chan.run & ~$past(cfg.beh)) == 4'h0 && chan.freeze == $past(cfg.beh)))
    else $error("enable low did not apply the per-channel behaviour");

  a_beh_default_off: assert property (@(posedge pclk)
    $rose(presetn) |-> (cfg.beh == 4'h0))
    else $error("enable behaviour not off after reset");

  a_serial_resync: assert property (@(posedge pclk) disable iff (!presetn)
    ($changed(serial_msg_toggle) && rst_pin_s && sup_a_s && sup_d_s) |-> ##[2:4] serial_msg)
    else $error("serial event not seen in pclk domain");

  a_delay_slot_start: assert property (@(posedge pclk) disable iff (!presetn)
    chan.start[0] |-> $past(cnt == slot_pos(cfg.delay[`CPSL_DLY_W-1:0], cfg.period)))
    else $error("channel start not at its delay slot");

  a_align_restart: assert property (@(posedge pclk) disable iff (!presetn)
    s_align_event |=> s_restart)
    else $error("period not restarted by alignment edge");

  a_align_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    s_align_event |=> s_flag_kept)
    else $error("alignment flag not set or not held");

  a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (stat_read && !align_rise && !soft_rst) |=> !align_seen)
    else $error("alignment flag not cleared by status read");

  a_fault_pulldown: assert property (@(posedge pclk) disable iff (!presetn)
    ((|(fault_detect & ~cfg.mask)) && !soft_rst) |=> (!fault_oe_n && !fault_out))
    else $error("unmasked fault did not pull the pin low");

  a_align_sync_edge: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(align_pin) && mode != M_RESET) |-> ##[2:4] align_rise)
    else $error("alignment edge not detected after two flops");
endmodule

// ### bench/cpsl_host.sv
// host microcontroller model that drives the control pins
`timescale 1ns/10ps
module cpsl_host #(
  parameter int MIN_GAP = 40
) (
  input  wire logic pclk,
  output logic      chip_reset_n,
  output logic      analog_supply_ok,
  output logic      digital_supply_ok,
  output logic      enable_pin,
  output logic      align_pin,
  output logic      serial_msg_toggle
);
  // ****************************************
  // pin sequences
  // ****************************************
  // everything down at power-on
  initial begin
    chip_reset_n = 1'b0;
    analog_supply_ok = 1'b0;
    digital_supply_ok = 1'b0;
    enable_pin = 1'b0;
    align_pin = 1'b0;
    serial_msg_toggle = 1'b0;
  end
  // supplies settle before the reset pin lets go
  task automatic power_up();
    @(posedge pclk);
    analog_supply_ok <= 1'b1;
    digital_supply_ok <= 1'b1;
    repeat (4) @(posedge pclk);
    chip_reset_n <= 1'b1;
    enable_pin <= 1'b1;
  endtask
  // 0 analog supply dip, 1 digital supply dip, 2 reset pin pulse
  task automatic glitch_down(input int which);
    @(posedge pclk);
    if (which == 0) analog_supply_ok <= 1'b0;
    if (which == 1) digital_supply_ok <= 1'b0;
    if (which == 2) chip_reset_n <= 1'b0;
  endtask
  task automatic glitch_up();
    @(posedge pclk);
    analog_supply_ok <= 1'b1;
    digital_supply_ok <= 1'b1;
    repeat (4) @(posedge pclk);
    chip_reset_n <= 1'b1;
  endtask
  task automatic set_en(input logic v);
    @(posedge pclk);
    enable_pin <= v;
  endtask
  // spacing keeps edges rare; a pulse train would upset regulation
  task automatic align_rise();
    repeat (MIN_GAP) @(posedge pclk);
    align_pin <= 1'b1;
  endtask
  task automatic align_fall();
    @(posedge pclk);
    align_pin <= 1'b0;
  endtask
  // one message boundary in the serial domain
  task automatic msg();
    @(posedge pclk);
    serial_msg_toggle <= ~serial_msg_toggle;
    repeat (5) @(posedge pclk);
  endtask
endmodule

// ### bench/control_pin_sync_logic_bench.sv
// self-checking bench of the control-pin block against a behavioural model
`timescale 1ns/10ps
`include "cpsl_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module control_pin_sync_logic_bench;
  import cpsl_pkg::*;
  localparam int PER = 64;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, arm;
  logic serial_msg, fault_out, fault_oe_n;
  logic chip_reset_n, analog_supply_ok, digital_supply_ok, enable_pin, align_pin, serial_msg_toggle;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, m_ctrl, m_dly, m_mask;
  logic [3:0]  fault_detect;
  cpsl_chan_s  chan;
  int          seed, cyc, n_mismatch, comparisons, nmsg, e0;
  int          t[4], d[4];
  cpsl_ctrl #(.PERIOD_CLKS(PER)) u_cpsl_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_reset_n(chip_reset_n),
    .analog_supply_ok(analog_supply_ok), .digital_supply_ok(digital_supply_ok),
    .enable_pin(enable_pin), .align_pin(align_pin), .serial_msg_toggle(serial_msg_toggle),
    .fault_detect(fault_detect), .chan(chan), .serial_msg(serial_msg), .fault_out(fault_out),
    .fault_oe_n(fault_oe_n));
  cpsl_host u_cpsl_host (.pclk(pclk), .chip_reset_n(chip_reset_n), .analog_supply_ok(analog_supply_ok),
    .digital_supply_ok(digital_supply_ok), .enable_pin(enable_pin), .align_pin(align_pin),
    .serial_msg_toggle(serial_msg_toggle));
  // ****************************************
  // clock, watchdog and monitors
  // ****************************************
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  // first start pulse per channel once armed; the ceiling cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (serial_msg === 1'b1) nmsg++;
    for (int i = 0; i < 4; i++) begin
      if (arm === 1'b1 && chan.start[i] === 1'b1 && t[i] < 0) t[i] = cyc;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // apb transfer: setup, then access held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait that never gets pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // write that also updates the model
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
    case (a)
      `CPSL_OFS_CTRL: m_ctrl = v & 32'hF;
      `CPSL_OFS_DELAY: m_dly = v & 32'h1F1F1F1F;
      `CPSL_OFS_FMASK: m_mask = v & 32'hF;
      default: ;
    endcase
  endtask
  function automatic logic [31:0] mdl(input logic [7:0] a);
    if (a == `CPSL_OFS_CTRL) return m_ctrl;
    if (a == `CPSL_OFS_DELAY) return m_dly;
    return m_mask;
  endfunction
  // enable high runs all channels, low gives off or freeze per setting
  task automatic en_check();
    repeat (8) @(posedge pclk);
    `CHK("run enabled", 4'hF, chan.run);
    u_cpsl_host.set_en(1'b0);
    repeat (8) @(posedge pclk);
    `CHK("run disabled", m_ctrl[3:0], chan.run);
    `CHK("frozen", m_ctrl[3:0], chan.freeze);
    u_cpsl_host.set_en(1'b1);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fault_detect, arm} = '0;
    {m_ctrl, m_dly, m_mask} = '0;
    seed = 13;
    {cyc, n_mismatch, comparisons, nmsg} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    u_cpsl_host.power_up();
    repeat (4) @(posedge pclk);
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      `CHK("reset value", 32'h0, rd);
    end
    apb(1'b0, `CPSL_OFS_PERIOD, 32'h0);
    `CHK("period", PER, rd);
    apb(1'b1, 8'h14, 32'h0);
    `CHK("unmapped err", 1'b1, err);
    // random settings read back through the model
    for (int k = 0; k < 6; k++) begin
      wr(8'(4 * (k % 3)), $random(seed));
      apb(1'b0, 8'(4 * (k % 3)), 32'h0);
      `CHK("readback", mdl(8'(4 * (k % 3))), rd);
    end
    // two alignment events with the same random offsets
    for (int i = 0; i < 4; i++) d[i] = 1 + (($random(seed) & 32'hFFFF) % 31);
    wr(`CPSL_OFS_DELAY, d[0] | (d[1] << 8) | (d[2] << 16) | (d[3] << 24));
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) t[i] = -1;
      u_cpsl_host.align_rise();
      e0 = cyc;
      repeat (4) @(posedge pclk);
      arm <= 1'b1;
      repeat (PER + 4) @(posedge pclk);
      arm <= 1'b0;
      u_cpsl_host.align_fall();
      for (int i = 1; i < 4; i++) `CHK("start offset", (PER / 32) * (d[i] - d[0]), t[i] - t[0]);
      // two sync flops, edge detect, restart edge, registered start pulse: 5 edges plus the slots
      `CHK("restart latency", 5 + (PER / 32) * d[0], t[0] - e0);
      apb(1'b0, `CPSL_OFS_STATUS, 32'h0);
      `CHK("align flag set", 1'b1, rd[0]);
      apb(1'b0, `CPSL_OFS_STATUS, 32'h0);
      `CHK("align flag clear", 1'b0, rd[0]);
    end
    // every channel in both behaviours
    for (int k = 0; k < 2; k++) begin
      wr(`CPSL_OFS_CTRL, k ? 32'hA : 32'h5);
      en_check();
    end
    // fault pin against random faults and masks
    for (int k = 0; k < 8; k++) begin
      wr(`CPSL_OFS_FMASK, $random(seed));
      fault_detect <= 4'($random(seed));
      repeat (3) @(posedge pclk);
      `CHK("fault pin", ((fault_detect & ~m_mask[3:0]) == 4'h0), fault_oe_n);
      `CHK("fault data", 1'b0, fault_out);
      // whole status word: enable, pin state, running channels, raw faults, run mode
      apb(1'b0, `CPSL_OFS_STATUS, 32'h0);
      `CHK("status word", 14'h10F2 | (14'(fault_detect) << 8) | (14'((fault_detect & ~m_mask[3:0]) != 4'h0) << 2), rd[13:0]);
    end
    nmsg = 0;
    repeat (5) u_cpsl_host.msg();
    repeat (4) @(posedge pclk);
    `CHK("serial msgs", 5, nmsg);
    // supply dips and reset pin: channels off, settings back to defaults
    for (int w = 0; w < 3; w++) begin
      wr(`CPSL_OFS_CTRL, 32'hF);
      u_cpsl_host.glitch_down(w);
      repeat (6) @(posedge pclk);
      `CHK("run in reset", 4'h0, chan.run);
      wr(`CPSL_OFS_DELAY, 32'h1F);
      u_cpsl_host.glitch_up();
      repeat (4) @(posedge pclk);
      {m_ctrl, m_dly, m_mask} = '0;
      apb(1'b0, `CPSL_OFS_CTRL, 32'h0);
      `CHK("ctrl after reset", 32'h0, rd);
      apb(1'b0, `CPSL_OFS_DELAY, 32'h0);
      `CHK("delay after reset", 32'h0, rd);
      en_check();
    end
    summarize();
  end
endmodule
